// [hw/fic_host.sv]
// host controller that drives the flash pins for id and security-code access
`include "fic_defs.svh"

module fic_host import fic_pkg::*; #(
  parameter int ADDR_W = 22 // address width, top_address_bit = ADDR_W-1
) (
  input wire logic clk_i, // 100 MHz clock
  input wire logic resetn_i, // async reset, active low
  input wire logic cmd_valid_i, // request strobe
  output logic cmd_ready_o, // controller idle
  input wire fic_op_t cmd_op_i, // requested operation
  input wire logic [ADDR_W-1:0] cmd_addr_i, // read or program address
  input wire logic [15:0] cmd_data_i, // program data
  output logic rsp_valid_o, // one-cycle completion pulse
  output logic [15:0] rsp_data_o, // read data
  output logic [ADDR_W-1:0] flash_addr_o, // address pins
  input wire logic [15:0] bidir_word_lines_i, // data pins in
  output logic [15:0] bidir_word_lines_o, // data pins out
  output logic bidir_word_lines_oe_o, // high while host drives data
  output logic flash_ce_n_o, // chip select, low active
  output logic flash_oe_n_o, // output gate, low active
  output logic flash_we_n_o, // write strobe, low active
  output logic flash_rst_n_o, // device reset, low active
  output logic flash_wp_n_o // boot guard, low protects
);
  // elaboration guard: the unlock offsets need 15 bits and the pins stop at 24
  if (ADDR_W < 16 || ADDR_W > 24) begin : g_bad_addr_w
    $error("fic_host: ADDR_W out of range");
  end

  typedef struct packed {
    fic_state_t st;
    fic_op_t op;
    logic [2:0] idx;
    logic [2:0] nwr;
    logic [3:0] cnt;
    logic [7:0] rcnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] tgt; // command target; addr is reused for the unlock writes
    logic [15:0] wdat;
    logic [15:0] dout;
    logic oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic poll;
    logic have_prev;
    logic [15:0] prev;
    logic [15:0] rdat;
    logic rsp;
    logic [15:0] s0;
    logic [15:0] s1;
  } fic_regs_t;

  fic_regs_t r;
  fic_regs_t next_r;

  // address and data of write number i of a command
  function automatic logic [ADDR_W+15:0] wr_word(input fic_op_t op, input logic [2:0] i,
                                                 input logic [ADDR_W-1:0] a,
                                                 input logic [15:0] d);
    logic [ADDR_W-1:0] ua1;
    logic [ADDR_W-1:0] ua2;
    ua1 = ADDR_W'(`FIC_UNLOCK_ADDR1);
    ua2 = ADDR_W'(`FIC_UNLOCK_ADDR2);
    unique case (i)
      3'h0: wr_word = {ua1, `FIC_UNLOCK_DATA1};
      3'h1: wr_word = {ua2, `FIC_UNLOCK_DATA2};
      3'h2: begin
        unique case (op)
          FIC_OP_ID_ENTRY: wr_word = {ua1, `FIC_CMD_ID_ENTRY};
          FIC_OP_SEC_ENTRY: wr_word = {ua1, `FIC_CMD_SEC_ENTRY};
          FIC_OP_SEC_PROG: wr_word = {ua1, `FIC_CMD_SEC_PROG};
          FIC_OP_SEC_LOCK: wr_word = {ua1, `FIC_CMD_SEC_LOCK};
          default: wr_word = {ua1, `FIC_CMD_EXIT};
        endcase
      end
      default: begin
        if (op == FIC_OP_SEC_LOCK) wr_word = {a, `FIC_LOCK_DATA};
        else wr_word = {a, d};
      end
    endcase
  endfunction

  // two-flop synchroniser on the data pins; only the second stage is read
  logic [15:0] din_meta;
  logic [15:0] din_sync;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      din_meta <= 16'h0000;
      din_sync <= 16'h0000;
    end else begin
      din_meta <= bidir_word_lines_i;
      din_sync <= din_meta;
    end
  end

  // next-state logic for all controller state
  always_comb begin
    logic [ADDR_W+15:0] w;
    w = '0;
    next_r = r;
    next_r.rsp = 1'b0;
    unique case (r.st)
      FIC_IDLE: begin
        next_r.ce_n = 1'b1;
        next_r.oe_n = 1'b1;
        next_r.we_n = 1'b1;
        next_r.oe = 1'b0;
        // nothing is taken while the device reset is still low, matching cmd_ready_o
        if (cmd_valid_i && r.rst_n) begin
          next_r.op = cmd_op_i;
          next_r.idx = 3'h0;
          next_r.cnt = 4'h0;
          next_r.addr = cmd_addr_i;
          next_r.tgt = cmd_addr_i;
          next_r.wdat = cmd_data_i;
          next_r.have_prev = 1'b0;
          unique case (cmd_op_i)
            FIC_OP_READ: begin
              next_r.ce_n = 1'b0;
              next_r.oe_n = 1'b0;
              next_r.st = FIC_RD_WAIT;
            end
            FIC_OP_RESET: begin
              next_r.rst_n = 1'b0;
              next_r.rcnt = 8'h00;
              next_r.st = FIC_RST_LOW;
            end
            default: begin
              next_r.nwr = (cmd_op_i == FIC_OP_SEC_PROG || cmd_op_i == FIC_OP_SEC_LOCK)
                           ? 3'h4 : 3'h3;
              next_r.st = FIC_SETUP;
            end
          endcase
        end
      end
      FIC_SETUP: begin
        // address and data settle before the strobe falls
        w = wr_word(r.op, r.idx, r.tgt, r.wdat);
        next_r.addr = w[ADDR_W+15:16];
        next_r.dout = w[15:0];
        next_r.oe = 1'b1;
        next_r.ce_n = 1'b0;
        next_r.oe_n = 1'b1;
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == `FIC_SETUP_CYC) begin
          next_r.we_n = 1'b0;
          next_r.cnt = 4'h0;
          next_r.st = FIC_PULSE;
        end
      end
      FIC_PULSE: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == `FIC_PULSE_CYC) begin
          next_r.we_n = 1'b1; // the device latches data on this edge
          next_r.cnt = 4'h0;
          next_r.st = FIC_HOLD;
        end
      end
      FIC_HOLD: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == `FIC_HOLD_CYC) begin
          next_r.cnt = 4'h0;
          next_r.ce_n = 1'b1;
          next_r.oe = 1'b0; // data need not be held past the cycle
          next_r.idx = r.idx + 3'h1;
          if (r.idx + 3'h1 != r.nwr) begin
            next_r.st = FIC_SETUP;
          end else if (r.op == FIC_OP_SEC_PROG || r.op == FIC_OP_SEC_LOCK) begin
            // completion is seen by the toggle bit only, not data polling
            next_r.poll = 1'b1;
            next_r.ce_n = 1'b0;
            next_r.oe_n = 1'b0;
            next_r.st = FIC_RD_WAIT;
          end else begin
            next_r.rsp = 1'b1;
            next_r.st = FIC_IDLE;
          end
        end
      end
      FIC_RD_WAIT: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == `FIC_READ_CYC) begin
          next_r.cnt = 4'h0;
          next_r.ce_n = 1'b1;
          next_r.oe_n = 1'b1;
          if (r.poll) begin
            next_r.st = FIC_POLL;
          end else begin
            next_r.rdat = din_sync;
            next_r.rsp = 1'b1;
            next_r.st = FIC_IDLE;
          end
        end
      end
      FIC_POLL: begin
        // two reads with a steady toggle bit mean the write finished
        next_r.prev = din_sync;
        next_r.have_prev = 1'b1;
        if (r.have_prev &&
            (r.prev[`FIC_TOGGLE_BIT] == din_sync[`FIC_TOGGLE_BIT])) begin
          next_r.poll = 1'b0;
          next_r.rdat = din_sync;
          next_r.rsp = 1'b1;
          next_r.st = FIC_IDLE;
        end else begin
          next_r.ce_n = 1'b0;
          next_r.oe_n = 1'b0;
          next_r.st = FIC_RD_WAIT;
        end
      end
      FIC_RST_LOW: begin
        next_r.rcnt = r.rcnt + 8'h01;
        if (r.rcnt == `FIC_RST_CYC) begin
          next_r.rst_n = 1'b1;
          next_r.rcnt = 8'h00;
          next_r.st = FIC_RST_REC;
        end
      end
      FIC_RST_REC: begin
        next_r.rcnt = r.rcnt + 8'h01;
        if (r.rcnt == `FIC_RST_REC_CYC) begin
          next_r.rsp = 1'b1;
          next_r.st = FIC_IDLE;
        end
      end
      default: next_r.st = FIC_IDLE;
    endcase
  end

  // state register; the device is held in reset while the host is
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.st <= FIC_IDLE;
      r.op <= FIC_OP_READ;
      r.ce_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.rst_n <= 1'b0;
    end else begin
      r <= next_r;
      if (r.st == FIC_IDLE && !r.rst_n) r.rst_n <= 1'b1;
    end
  end

  assign cmd_ready_o = (r.st == FIC_IDLE) && r.rst_n;
  assign rsp_valid_o = r.rsp;
  assign rsp_data_o = r.rdat;
  assign flash_addr_o = r.addr;
  assign bidir_word_lines_o = r.dout;
  assign bidir_word_lines_oe_o = r.oe; // never with the gate low
  assign flash_ce_n_o = r.ce_n;
  assign flash_oe_n_o = r.oe_n;
  assign flash_we_n_o = r.we_n;
  assign flash_rst_n_o = r.rst_n;
  assign flash_wp_n_o = 1'b1; // boot block left writable; no erase issued here
endmodule // fic_host

// [hw/fic_defs.svh]
// constants of the flash identification and security-code host controller
`ifndef FIC_DEFS_SVH
`define FIC_DEFS_SVH
`define FIC_UNLOCK_ADDR1 15'h5555
`define FIC_UNLOCK_ADDR2 15'h2AAA
`define FIC_UNLOCK_DATA1 16'h00AA
`define FIC_UNLOCK_DATA2 16'h0055
`define FIC_CMD_ID_ENTRY 16'h0090
`define FIC_CMD_SEC_ENTRY 16'h0088
`define FIC_CMD_EXIT 16'h00F0
`define FIC_CMD_SEC_PROG 16'h00A5
`define FIC_CMD_SEC_LOCK 16'h0085
`define FIC_LOCK_DATA 16'h0000
`define FIC_TOGGLE_BIT 6
`define FIC_SETUP_CYC 4'h2
`define FIC_PULSE_CYC 4'h5
`define FIC_HOLD_CYC 4'h2
`define FIC_READ_CYC 4'h8
`define FIC_RST_CYC 8'h32
`define FIC_RST_REC_CYC 8'h14
`endif

// [hw/fic_pkg.sv]
// types of the flash identification and security-code host controller
package fic_pkg;
  typedef enum logic [2:0] {
    FIC_OP_READ,     // plain read at cmd_addr_i
    FIC_OP_ID_ENTRY,
    FIC_OP_SEC_ENTRY,
    FIC_OP_EXIT,
    FIC_OP_SEC_PROG, // security word program at cmd_addr_i
    FIC_OP_SEC_LOCK,
    FIC_OP_RESET
  } fic_op_t;

  typedef enum logic [2:0] {
    FIC_IDLE,
    FIC_SETUP,
    FIC_PULSE,
    FIC_HOLD,
    FIC_RD_WAIT,
    FIC_POLL,
    FIC_RST_LOW,
    FIC_RST_REC
  } fic_state_t;
endpackage

// [dv/fic_host_assertions.sv]
// concurrent checks on the flash host controller pins
module fic_host_assertions import fic_pkg::*; #(
  parameter int ADDR_W = 22
) (
  input wire logic clk_i, // clock
  input wire logic resetn_i, // reset
  input wire logic cmd_valid_i, // request
  input wire logic cmd_ready_o, // idle
  input wire fic_op_t cmd_op_i, // op
  input wire logic rsp_valid_o, // done
  input wire logic [ADDR_W-1:0] flash_addr_o, // address
  input wire logic [15:0] bidir_word_lines_o, // data out
  input wire logic bidir_word_lines_oe_o, // drive
  input wire logic flash_ce_n_o, // select
  input wire logic flash_oe_n_o, // gate
  input wire logic flash_we_n_o, // strobe
  input wire logic flash_rst_n_o, // device reset
  input wire logic flash_wp_n_o // guard
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a taken read and the strobe's low phase
  sequence s_read_take;
    cmd_valid_i && cmd_ready_o && cmd_op_i == FIC_OP_READ;
  endsequence
  sequence s_strobe_hold;
    !flash_we_n_o [*6] ##1 flash_we_n_o;
  endsequence
  AST_READ_LAT: assert property (s_read_take |-> ##10 rsp_valid_o) else $error("read late");
  AST_WE_PULSE: assert property ($fell(flash_we_n_o) |-> s_strobe_hold) else $error("pulse");
  AST_OE_WE: assert property (!(!flash_oe_n_o && !flash_we_n_o)) else $error("gate+strobe");
  AST_WE_CE: assert property (!flash_we_n_o |-> !flash_ce_n_o) else $error("strobe no sel");
  AST_NO_FIGHT: assert property (bidir_word_lines_oe_o |-> flash_oe_n_o) else $error("fight");
  AST_GUARD: assert property (flash_wp_n_o) else $error("guard low");
  AST_RST_LOW: assert property ($fell(flash_rst_n_o) |-> !flash_rst_n_o [*8]) else $error("rst");
  AST_RSP_PULSE: assert property (rsp_valid_o |=> !rsp_valid_o) else $error("rsp width");
  AST_UNLOCK: assert property (!flash_we_n_o && bidir_word_lines_o inside {16'h00AA, 16'h0088}
    |-> flash_addr_o[14:0] == 15'h5555) else $error("unlock addr");
endmodule // fic_host_assertions

bind fic_host fic_host_assertions #(.ADDR_W(ADDR_W)) chk_u (.clk_i, .resetn_i, .cmd_valid_i,
  .cmd_ready_o, .cmd_op_i, .rsp_valid_o, .flash_addr_o, .bidir_word_lines_o,
  .bidir_word_lines_oe_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_rst_n_o,
  .flash_wp_n_o);

// [dv/fic_flash_model.sv]
// behavioural flash part answering the host controller pins
module fic_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h0011, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0022 // arbitrary value
) (
  input wire logic [21:0] addr_i, // address pins
  input wire logic [15:0] data_i, // host data
  input wire logic ce_n_i, // select
  input wire logic oe_n_i, // gate
  input wire logic we_n_i, // strobe
  input wire logic rst_n_i, // reset
  output logic [15:0] data_o // device data
);
  logic [15:0] sec [16]; // 0-7 factory, 8-15 user; no erase path exists
  logic [15:0] cmd = 16'h0000, last = 16'h0000, tog = 16'h0000;
  logic [1:0] mode = 2'd0, st = 2'd0;
  logic locked = 1'b0;
  int busy = 0;
  initial for (int i = 0; i < 16; i++) sec[i] = (i < 8) ? 16'h7A00 + 16'(i) : 16'hFFFF;
  // read path: id codes, security words or array pattern
  function automatic logic [15:0] rd(input logic [21:0] a);
    if (mode == 2'd1) return a[0] ? PART_CODE : MAKER_CODE;
    if (mode == 2'd2) return sec[a[3:0]];
    return a[15:0] ^ 16'hC3C3;
  endfunction
  // released lines show the inverse of the last word so stale data never passes
  assign data_o = (!ce_n_i && !oe_n_i) ? rd(addr_i) ^ tog : ~last;
  // status toggling advances once per finished read while busy, and clears once the program is done
  always @(posedge oe_n_i) begin
    last = rd(addr_i) ^ tog;
    tog = (busy > 0) ? tog ^ 16'h0040 : 16'h0000;
    if (busy > 0) busy--;
  end
  // command decode on the strobe's rising edge, data latched here
  always @(posedge we_n_i) if (ce_n_i === 1'b0) begin
    if (data_i == 16'h00F0 && busy == 0 && st != 2'd3) begin
      mode = 2'd0;
      st = 2'd0;
    end else case (st)
      2'd0: st = (addr_i[14:0] == 15'h5555 && data_i == 16'h00AA) ? 2'd1 : 2'd0;
      2'd1: st = (addr_i[14:0] == 15'h2AAA && data_i == 16'h0055) ? 2'd2 : 2'd0;
      2'd2: begin
        cmd = data_i;
        st = (data_i inside {16'h00A5, 16'h0085}) ? 2'd3 : 2'd0;
        if (data_i == 16'h0090) mode = 2'd1;
        if (data_i == 16'h0088) mode = 2'd2;
      end
      default: begin
        if (cmd == 16'h00A5 && !locked) begin
          sec[{1'b1, addr_i[2:0]}] &= data_i;
          busy = 3;
        end
        if (cmd == 16'h0085) locked = 1'b1;
        st = 2'd0;
      end
    endcase
  end
  // hardware reset returns to array read
  always @(negedge rst_n_i) begin
    mode = 2'd0;
    st = 2'd0;
    busy = 0;
    tog = 16'h0000;
  end
endmodule // fic_flash_model

// [dv/fic_host_tb.sv]
// testbench for the flash host controller against a flash model
module fic_host_tb import fic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MAKER = 16'h0011; // arbitrary value
  localparam logic [15:0] PART = 16'h0022; // arbitrary value
  logic clk_i = 0, resetn_i = 0, cmd_valid_i = 0, cmd_ready_o, rsp_valid_o, oe, ce_n, oe_n;
  logic we_n, rst_n, wp_n;
  fic_op_t cmd_op_i = FIC_OP_READ;
  logic [21:0] cmd_addr_i = 0, faddr;
  logic [15:0] cmd_data_i = 0, rsp_data_o, din, dout, rd;
  int n_fail = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  fic_host dut_u (.clk_i, .resetn_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_addr_i,
    .cmd_data_i, .rsp_valid_o, .rsp_data_o, .flash_addr_o(faddr),
    .bidir_word_lines_i(oe ? dout : din), .bidir_word_lines_o(dout), .bidir_word_lines_oe_o(oe),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_rst_n_o(rst_n),
    .flash_wp_n_o(wp_n));
  fic_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) mdl_u (.addr_i(faddr), .data_i(dout),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(rst_n), .data_o(din));
  // one request, held until taken, then bounded wait for the response
  task automatic op(input fic_op_t o, input logic [21:0] a = 0, input logic [15:0] d = 0);
    int n;
    @(negedge clk_i);
    cmd_op_i = o;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_valid_i = 1;
    for (n = 0; cmd_ready_o !== 1'b1 && n < 200; n++) @(negedge clk_i);
    if (n >= 200) n_fail++;
    @(negedge clk_i) cmd_valid_i = 0;
    for (n = 0; rsp_valid_o !== 1'b1 && n < 2000; n++) @(negedge clk_i);
    if (n >= 2000) n_fail++;
    rd = rsp_data_o;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_ident;
    op(FIC_OP_ID_ENTRY);
    op(FIC_OP_READ, 22'h0);
    chk(rd, MAKER);
    op(FIC_OP_READ, 22'h1);
    chk(rd, PART);
    op(FIC_OP_EXIT);
    op(FIC_OP_READ, 22'h1);
    chk(rd, 16'h0001 ^ 16'hC3C3);
  endtask
  task automatic t_secq;
    op(FIC_OP_SEC_ENTRY);
    op(FIC_OP_READ, 22'h3);
    chk(rd, 16'h7A03);
    op(FIC_OP_READ, 22'h9);
    chk(rd, 16'hFFFF);
    op(FIC_OP_EXIT);
    op(FIC_OP_READ, 22'h9);
    chk(rd, 16'h0009 ^ 16'hC3C3);
  endtask
  // program, lock, then a refused second program of the same word
  task automatic t_prog;
    op(FIC_OP_SEC_PROG, 22'h9, 16'h1234);
    op(FIC_OP_SEC_LOCK);
    op(FIC_OP_SEC_PROG, 22'h9, 16'h0F0F);
    op(FIC_OP_SEC_ENTRY);
    op(FIC_OP_READ, 22'h9);
    chk(rd, 16'h1234);
    op(FIC_OP_EXIT);
  endtask
  task automatic t_rst;
    op(FIC_OP_ID_ENTRY);
    op(FIC_OP_RESET);
    op(FIC_OP_READ, 22'h0);
    chk(rd, 16'hC3C3);
    op(FIC_OP_READ, 22'h2ABCDE);
    chk(rd, 16'hBCDE ^ 16'hC3C3);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i) resetn_i = 1;
    t_ident;
    t_secq;
    t_prog;
    t_rst;
    test_done;
  end
  // watchdog well beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    test_done;
  end
endmodule // fic_host_tb
